// ===== sdl_pkg.sv
// constants shared by both ends of the sdr latency parameter table link
package sdl_pkg;
  localparam int          BYTE_W      = 8;
  localparam int          NCMD        = 6;
  localparam logic [7:0]  PARAM_ID    = 8'h90;
  localparam logic [7:0]  PARAM_LEN   = 8'h56;
  localparam logic [7:0]  NUM_ROWS    = 8'h06;
  localparam logic [7:0]  ROW_LEN     = 8'h0E;
  localparam logic [7:0]  ASCII_F     = 8'h46;
  localparam logic [7:0]  ASCII_C     = 8'h43;
  localparam logic [7:0]  UNSUP       = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  ONE_BYTE    = 8'h01;
  localparam logic [7:0]  OFS_ID      = 8'h00;
  localparam logic [7:0]  OFS_LEN     = 8'h01;
  localparam logic [7:0]  OFS_NROWS   = 8'h02;
  localparam logic [7:0]  OFS_ROWLEN  = 8'h03;
  localparam logic [7:0]  OFS_HDR     = 8'h04;
  localparam logic [7:0]  ID_COUNT    = 8'h02;
  localparam logic [7:0]  COL_FREQ    = 8'h00;
  localparam logic [7:0]  COL_CODE    = 8'h01;
  localparam logic [7:0]  COL_CMD0    = 8'h02;
  localparam logic [2:0]  ROW_HDR     = 3'h0;
  localparam logic [2:0]  ROW_50      = 3'h1;
  localparam logic [2:0]  ROW_80      = 3'h2;
  localparam logic [7:0]  FREQ_50     = 8'h32;
  localparam logic [7:0]  CODE_50     = 8'h03;
  localparam logic [7:0]  FREQ_80     = 8'h50;
  localparam logic [7:0]  CODE_80     = 8'h00;
  // command columns, in table order
  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_FAST = 3'h1,
    CMD_DOUT = 3'h2,
    CMD_QOUT = 3'h3,
    CMD_DIO  = 3'h4,
    CMD_QIO  = 3'h5
  } sdl_cmd_type;
  localparam logic [7:0] OP3 [NCMD] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
  localparam logic [7:0] OP4 [NCMD] = '{8'h13, 8'h0C, 8'h3C, 8'h6C, 8'hBC, 8'hEC};
  localparam logic [7:0] MODE50 [NCMD] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02};
  localparam logic [7:0] LAT50 [NCMD]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  localparam logic [7:0] MODE80 [NCMD] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02};
  // last entry of this row is not known and is served from a device parameter
  localparam logic [7:0] LAT80 [NCMD]  = '{8'hFF, 8'h08, 8'h08, 8'h08, 8'h00, 8'hFF};
endpackage

// ===== sdl_link_if.sv
// byte-read link between the table device and its reader
`timescale 1ns/1ps
interface sdl_link_if (
  input wire logic clk_i,
  input wire logic reset_i
);
  logic       req_valid;
  logic [7:0] req_offset;
  logic [7:0] req_count;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_oor;
  modport dev  (input req_valid, req_offset, req_count,
                output req_ready, rsp_valid, rsp_data, rsp_last, rsp_oor);
  modport host (output req_valid, req_offset, req_count,
                input req_ready, rsp_valid, rsp_data, rsp_last, rsp_oor);
endinterface

// ===== sdl_byte_cap.sv
// one loadable byte register used by the reader
`timescale 1ns/1ps
module sdl_byte_cap #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         clear_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] q_o
);
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      q_o <= '0;
    end else if (load_i) begin
      q_o <= data_i;
    end
  end
endmodule // sdl_byte_cap

// ===== sdl_table_dev.sv
// device end: serves the sdr latency parameter table byte by byte
`timescale 1ns/1ps
module sdl_table_dev
  import sdl_pkg::*;
#(
  parameter logic [7:0] UNK_FILL = 8'hFF
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  sdl_link_if.dev   link,
  output logic      busy_o,
  output logic      oor_seen_o,
  output logic [7:0] served_o
);
  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_STREAM = 1'b1
  } sdl_dev_state_type;

  sdl_dev_state_type state_r;
  sdl_dev_state_type state_nxt;
  logic [7:0]        off_r;
  logic [7:0]        left_r;
  logic              take;
  logic              last_beat;
  logic [7:0]        rel;
  logic [2:0]        row;
  logic [7:0]        col;
  logic [7:0]        cmd_col;
  logic [2:0]        cmd;
  logic              is_lat;
  logic              in_param;
  logic [7:0]        tbl_byte;

  assign take      = (state_r == ST_IDLE) && link.req_valid && link.req_ready;
  assign last_beat = (state_r == ST_STREAM) && (left_r == ONE_BYTE);

  // a zero count is a no-op so a stray request cannot lock the link
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take && (link.req_count != ZERO_BYTE)) begin
          state_nxt = ST_STREAM;
        end
      end
      ST_STREAM: begin
        if (last_beat) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ready is registered, so it follows the state one cycle behind the decision
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      link.req_ready <= 1'b0;
    end else begin
      link.req_ready <= (state_nxt == ST_IDLE);
    end
  end

  // address walks up one byte per beat
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      off_r  <= ZERO_BYTE;
      left_r <= ZERO_BYTE;
    end else if (take) begin
      off_r  <= link.req_offset;
      left_r <= link.req_count;
    end else if (state_r == ST_STREAM) begin
      off_r  <= off_r + ONE_BYTE;
      left_r <= left_r - ONE_BYTE;
    end
  end

  // split the offset into row and column; rows are fixed length after the header
  always_comb begin
    rel = off_r - OFS_HDR;
    row = ROW_HDR;
    for (int r = 1; r < int'(NUM_ROWS); r++) begin
      if (rel >= 8'(r * int'(ROW_LEN))) begin
        row = 3'(r);
      end
    end
    col     = rel - 8'(int'(row) * int'(ROW_LEN));
    cmd_col = col - COL_CMD0;
    cmd     = cmd_col[3:1];
    is_lat  = cmd_col[0];
  end

  assign in_param = (off_r <= (PARAM_LEN + OFS_LEN));

  // contents are constants only; nothing can write them
  always_comb begin
    tbl_byte = UNK_FILL;
    if (!in_param) begin
      tbl_byte = UNSUP;
    end else if (off_r == OFS_ID) begin
      tbl_byte = PARAM_ID;
    end else if (off_r == OFS_LEN) begin
      tbl_byte = PARAM_LEN;
    end else if (off_r == OFS_NROWS) begin
      tbl_byte = NUM_ROWS;
    end else if (off_r == OFS_ROWLEN) begin
      tbl_byte = ROW_LEN;
    end else if (row == ROW_HDR) begin
      if (col == COL_FREQ) begin
        tbl_byte = ASCII_F;
      end else if (col == COL_CODE) begin
        tbl_byte = ASCII_C;
      end else if (is_lat) begin
        tbl_byte = OP4[cmd];
      end else begin
        tbl_byte = OP3[cmd];
      end
    end else if (row == ROW_50) begin
      if (col == COL_FREQ) begin
        tbl_byte = FREQ_50;
      end else if (col == COL_CODE) begin
        tbl_byte = CODE_50;
      end else if (is_lat) begin
        tbl_byte = LAT50[cmd];
      end else begin
        tbl_byte = MODE50[cmd];
      end
    end else if (row == ROW_80) begin
      if (col == COL_FREQ) begin
        tbl_byte = FREQ_80;
      end else if (col == COL_CODE) begin
        tbl_byte = CODE_80;
      end else if (is_lat && (cmd == CMD_QIO)) begin
        tbl_byte = UNK_FILL;
      end else if (is_lat) begin
        tbl_byte = LAT80[cmd];
      end else begin
        tbl_byte = MODE80[cmd];
      end
    end
  end

  // answer path is one register deep, every output from a flop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data  <= ZERO_BYTE;
      link.rsp_last  <= 1'b0;
      link.rsp_oor   <= 1'b0;
    end else if (state_r == ST_STREAM) begin
      link.rsp_valid <= 1'b1;
      link.rsp_data  <= tbl_byte;
      link.rsp_last  <= last_beat;
      link.rsp_oor   <= !in_param;
    end else begin
      link.rsp_valid <= 1'b0;
      link.rsp_data  <= ZERO_BYTE;
      link.rsp_last  <= 1'b0;
      link.rsp_oor   <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_nxt == ST_STREAM);
    end
  end

  // sticky until reset: a reader walking past the end is a reader bug
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oor_seen_o <= 1'b0;
    end else if ((state_r == ST_STREAM) && !in_param) begin
      oor_seen_o <= 1'b1;
    end
  end

  // wraps; a diagnostic only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      served_o <= ZERO_BYTE;
    end else if (state_r == ST_STREAM) begin
      served_o <= served_o + ONE_BYTE;
    end
  end
endmodule // sdl_table_dev

// ===== sdl_table_host.sv
// reader end: walks the table and picks out one command's cycle counts
`timescale 1ns/1ps
module sdl_table_host
  import sdl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  sdl_link_if.host        link,
  input  wire logic       start_i,
  input  wire logic [2:0] cmd_sel_i,
  input  wire logic [1:0] lat_code_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            error_o,
  output logic            found_o,
  output logic            supported_o,
  output logic [7:0]      freq_o,
  output logic [7:0]      op3_o,
  output logic [7:0]      op4_o,
  output logic [7:0]      mode_o,
  output logic [7:0]      lat_o
);
  typedef enum logic [2:0] {
    HS_IDLE     = 3'h0,
    HS_REQ_ID   = 3'h1,
    HS_RCV_ID   = 3'h2,
    HS_REQ_BODY = 3'h3,
    HS_RCV_BODY = 3'h4
  } sdl_host_state_type;

  sdl_host_state_type state_r;
  logic [2:0]  cmd_r;
  logic [1:0]  code_r;
  logic [7:0]  idx_r;
  logic [7:0]  rowlen_r;
  logic [7:0]  pos_r;
  logic [2:0]  row_r;
  logic        id_ok_r;
  logic        match_r;
  logic [7:0]  freq_tmp_r;
  logic [7:0]  col_m;
  logic        beat;
  logic        body;
  logic        cap_op3;
  logic        cap_op4;
  logic        cap_mode;
  logic        cap_lat;
  logic        cap_freq;
  logic        clr;

  assign beat  = link.rsp_valid;
  assign body  = (state_r == HS_RCV_BODY) && beat && (idx_r >= OFS_HDR);
  assign col_m = COL_CMD0 + {4'h0, cmd_r, 1'b0};
  assign clr   = (state_r == HS_IDLE) && start_i;
  assign cap_op3  = body && (row_r == ROW_HDR) && (pos_r == col_m);
  assign cap_op4  = body && (row_r == ROW_HDR) && (pos_r == col_m + ONE_BYTE);
  assign cap_freq = body && (row_r != ROW_HDR) && (pos_r == COL_CODE)
                    && !found_o && (link.rsp_data[1:0] == code_r);
  assign cap_mode = body && match_r && (pos_r == col_m);
  assign cap_lat  = body && match_r && (pos_r == col_m + ONE_BYTE);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r        <= HS_IDLE;
      link.req_valid <= 1'b0;
      link.req_offset <= ZERO_BYTE;
      link.req_count <= ZERO_BYTE;
      idx_r          <= ZERO_BYTE;
    end else begin
      if (beat) begin
        idx_r <= idx_r + ONE_BYTE;
      end
      unique case (state_r)
        HS_IDLE: begin
          if (start_i) begin
            state_r         <= HS_REQ_ID;
            link.req_valid  <= 1'b1;
            link.req_offset <= OFS_ID;
            link.req_count  <= ID_COUNT;
            idx_r           <= OFS_ID;
          end
        end
        HS_REQ_ID: begin
          if (link.req_ready) begin
            link.req_valid <= 1'b0;
            state_r        <= HS_RCV_ID;
          end
        end
        HS_RCV_ID: begin
          if (beat && link.rsp_last) begin
            if (id_ok_r) begin
              // body is exactly the length byte's count, starting after it
              state_r         <= HS_REQ_BODY;
              link.req_valid  <= 1'b1;
              link.req_offset <= OFS_NROWS;
              link.req_count  <= link.rsp_data;
              idx_r           <= OFS_NROWS;
            end else begin
              state_r <= HS_IDLE;
            end
          end
        end
        HS_REQ_BODY: begin
          if (link.req_ready) begin
            link.req_valid <= 1'b0;
            state_r        <= HS_RCV_BODY;
          end
        end
        HS_RCV_BODY: begin
          if (beat && link.rsp_last) begin
            state_r <= HS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || clr) begin
      id_ok_r  <= 1'b0;
      rowlen_r <= ROW_LEN;
      cmd_r    <= cmd_sel_i;
      code_r   <= lat_code_i;
    end else if (beat && (state_r == HS_RCV_ID)) begin
      if (idx_r == OFS_ID) begin
        id_ok_r <= (link.rsp_data == PARAM_ID);
      end
    end else if (beat && (state_r == HS_RCV_BODY) && (idx_r == OFS_ROWLEN)) begin
      rowlen_r <= link.rsp_data;
    end
  end

  // position within a row, wrapping at the length the table itself reports
  always_ff @(posedge clk_i) begin
    if (reset_i || clr) begin
      pos_r      <= ZERO_BYTE;
      row_r      <= ROW_HDR;
      match_r    <= 1'b0;
      freq_tmp_r <= ZERO_BYTE;
      found_o    <= 1'b0;
    end else if (body) begin
      if (pos_r == rowlen_r - ONE_BYTE) begin
        pos_r   <= ZERO_BYTE;
        row_r   <= row_r + 3'h1;
        match_r <= 1'b0;
      end else begin
        pos_r <= pos_r + ONE_BYTE;
      end
      if ((row_r != ROW_HDR) && (pos_r == COL_FREQ)) begin
        freq_tmp_r <= link.rsp_data;
      end
      // first matching row wins
      if (cap_freq) begin
        match_r <= 1'b1;
        found_o <= 1'b1;
      end
    end
  end

  sdl_byte_cap u_op3  (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clr), .load_i(cap_op3),
                       .data_i(link.rsp_data), .q_o(op3_o));
  sdl_byte_cap u_op4  (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clr), .load_i(cap_op4),
                       .data_i(link.rsp_data), .q_o(op4_o));
  sdl_byte_cap u_freq (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clr), .load_i(cap_freq),
                       .data_i(freq_tmp_r), .q_o(freq_o));
  sdl_byte_cap u_mode (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clr), .load_i(cap_mode),
                       .data_i(link.rsp_data), .q_o(mode_o));
  sdl_byte_cap u_lat  (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clr), .load_i(cap_lat),
                       .data_i(link.rsp_data), .q_o(lat_o));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      error_o     <= 1'b0;
      supported_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clr) begin
        busy_o      <= 1'b1;
        error_o     <= 1'b0;
        supported_o <= 1'b0;
      end else if ((state_r == HS_RCV_ID) && beat && link.rsp_last && !id_ok_r) begin
        busy_o  <= 1'b0;
        done_o  <= 1'b1;
        error_o <= 1'b1;
      end else if ((state_r == HS_RCV_BODY) && beat && link.rsp_last) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        // the last latency byte may land in this very beat
        supported_o <= found_o && (mode_o != UNSUP) && (lat_o != UNSUP)
                       && !(cap_lat && (link.rsp_data == UNSUP));
      end
    end
  end
endmodule // sdl_table_host

// ===== sdl_link_checker.sv
// concurrent checks on the table link between device and reader
`timescale 1ns/1ps
module sdl_link_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       req_valid,
  input wire logic [7:0] req_offset,
  input wire logic [7:0] req_count,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  input wire logic       rsp_oor
);
  localparam logic [7:0] HDR [12] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
                                      8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC};
  logic       take;
  logic [7:0] ofs_r;
  logic [7:0] rem_r;
  assign take = req_valid && req_ready;
  // a new take wins over the last byte of the previous burst in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ofs_r <= 8'h00;
    end else if (take) begin
      ofs_r <= req_offset;
    end else if (rsp_valid) begin
      ofs_r <= ofs_r + 8'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rem_r <= 8'h00;
    end else if (take) begin
      rem_r <= req_count;
    end else if (rsp_valid) begin
      rem_r <= rem_r - 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_id_byte: assert property (rsp_valid && ofs_r == 8'h00 |-> rsp_data == 8'h90)
    else $error("id byte wrong");
  a_len_byte: assert property (rsp_valid && ofs_r == 8'h01 |-> rsp_data == 8'h56)
    else $error("length byte wrong");
  a_hdr_ascii: assert property (rsp_valid && ofs_r == 8'h04 |->
    rsp_data == 8'h46 ##1 rsp_valid && rsp_data == 8'h43)
    else $error("header ascii wrong");
  a_hdr_opcodes: assert property (rsp_valid && ofs_r >= 8'h06 && ofs_r <= 8'h11 |->
    rsp_data == HDR[ofs_r - 8'h06])
    else $error("header opcode wrong");
  a_row50_head: assert property (rsp_valid && ofs_r == 8'h12 |->
    rsp_data == 8'h32 ##1 rsp_valid && rsp_data == 8'h03)
    else $error("row two head wrong");
  a_row80_head: assert property (rsp_valid && ofs_r == 8'h20 |->
    rsp_data == 8'h50 ##1 rsp_valid && rsp_data == 8'h00)
    else $error("row three head wrong");
  a_unsup_read: assert property (rsp_valid && ofs_r == 8'h22 |->
    rsp_data == 8'hFF ##1 rsp_valid && rsp_data == 8'hFF)
    else $error("unsupported marker wrong");
  a_answer_lat: assert property (take && req_count != 8'h00 |=> !req_ready ##1 rsp_valid)
    else $error("first byte late or early");
  a_last_count: assert property (rsp_valid |-> rsp_last == (rem_r == 8'h01))
    else $error("last flag misplaced");
  a_in_param: assert property (rsp_valid && !rsp_oor |-> ofs_r <= 8'h57)
    else $error("byte past parameter end");
  c_take_id: cover property (take && req_offset == 8'h00);
  c_take_body: cover property (take && req_count == 8'h56);
  c_last_fill: cover property (rsp_valid && rsp_last && rsp_data == 8'hFF);
endmodule // sdl_link_checker

// ===== tb_top.sv
// testbench: reader against device, plus raw byte reads of a second device
`timescale 1ns/1ps
module tb_top;
  // bytes 00h..2Dh of the parameter; 2Dh is unknown and filled with all ones
  localparam logic [7:0] EXP [46] = '{
    8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43, 8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C,
    8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01, 8'h50, 8'h00, 8'hFF, 8'hFF,
    8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'hFF};
  logic       clk_i;
  logic       reset_i;
  logic       start_i;
  logic [2:0] cmd_sel_i;
  logic [1:0] lat_code_i;
  logic       done_o;
  logic       error_o;
  logic       found_o;
  logic       supported_o;
  logic [7:0] freq_o;
  logic [7:0] op3_o;
  logic [7:0] op4_o;
  logic [7:0] mode_o;
  logic [7:0] lat_o;
  logic       oor_seen;
  logic       hbusy;
  logic       dbusy;
  logic [7:0] served;
  logic [7:0] got [256];
  logic       goor [256];
  logic       glast [256];
  logic [7:0] m;
  logic [7:0] l;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         cycles = 0;
  sdl_link_if l1 (.clk_i(clk_i), .reset_i(reset_i));
  sdl_link_if l2 (.clk_i(clk_i), .reset_i(reset_i));
  sdl_table_dev i_sdl_table_dev (.clk_i(clk_i), .reset_i(reset_i), .link(l1), .busy_o(),
    .oor_seen_o(), .served_o());
  sdl_table_host i_sdl_table_host (.clk_i(clk_i), .reset_i(reset_i), .link(l1),
    .start_i(start_i), .cmd_sel_i(cmd_sel_i), .lat_code_i(lat_code_i), .busy_o(hbusy),
    .done_o(done_o), .error_o(error_o), .found_o(found_o), .supported_o(supported_o),
    .freq_o(freq_o), .op3_o(op3_o), .op4_o(op4_o), .mode_o(mode_o), .lat_o(lat_o));
  // second device, read directly by the bench to see every raw byte
  sdl_table_dev i_sdl_table_dev_2 (.clk_i(clk_i), .reset_i(reset_i), .link(l2),
    .busy_o(dbusy), .oor_seen_o(oor_seen), .served_o(served));
  sdl_link_checker i_sdl_link_checker (.clk_i(clk_i), .reset_i(reset_i),
    .req_valid(l1.req_valid), .req_offset(l1.req_offset), .req_count(l1.req_count),
    .req_ready(l1.req_ready), .rsp_valid(l1.rsp_valid), .rsp_data(l1.rsp_data),
    .rsp_last(l1.rsp_last), .rsp_oor(l1.rsp_oor));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ceiling is well above eighteen walks of about a hundred cycles each
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request held until ready is seen at an edge; bytes collected where settled
  task automatic rd(input logic [7:0] ofs, input logic [7:0] cnt);
    int w;
    @(posedge clk_i);
    l2.req_valid <= 1'b1;
    l2.req_offset <= ofs;
    l2.req_count <= cnt;
    w = 0;
    do begin
      @(negedge clk_i);
      w++;
    end while (l2.req_ready !== 1'b1 && w < 50);
    // a ready that never came is a failure, not a silent skip
    if (l2.req_ready !== 1'b1) n_mismatch++;
    @(posedge clk_i);
    l2.req_valid <= 1'b0;
    for (int i = 0; i < cnt; i++) begin
      w = 0;
      @(negedge clk_i);
      while (l2.rsp_valid !== 1'b1 && w < 20) begin
        @(negedge clk_i);
        w++;
      end
      if (l2.rsp_valid !== 1'b1) n_mismatch++;
      got[i] = l2.rsp_data;
      goor[i] = l2.rsp_oor;
      glast[i] = l2.rsp_last;
      if (i == 0) chk("dev_busy", 8'(dbusy), 8'(cnt > 8'h01));
    end
  endtask
  task automatic job(input logic [2:0] c, input logic [1:0] code);
    int w;
    @(posedge clk_i);
    start_i <= 1'b1;
    cmd_sel_i <= c;
    lat_code_i <= code;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(negedge clk_i);
    chk("host_busy", 8'(hbusy), 8'h01);
    w = 0;
    do begin
      @(negedge clk_i);
      w++;
    end while (done_o !== 1'b1 && w < 400);
    chk("host_idle", 8'(hbusy), 8'h00);
  endtask
  initial begin
    reset_i = 1'b1;
    start_i = 1'b0;
    cmd_sel_i = 3'h0;
    lat_code_i = 2'h0;
    l2.req_valid = 1'b0;
    l2.req_offset = 8'h00;
    l2.req_count = 8'h00;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 8'h58);
    for (int i = 0; i < 88; i++) begin
      chk("table_byte", got[i], (i < 46) ? EXP[i] : 8'hFF);
      chk("table_oor", 8'(goor[i]), 8'h00);
    end
    chk("burst_last", 8'(glast[87]), 8'h01);
    chk("dev_idle", 8'(dbusy), 8'h00);
    rd(8'h58, 8'h02);
    chk("next_param_oor", 8'(goor[0]), 8'h01);
    chk("oor_fill", got[1], 8'hFF);
    chk("oor_sticky", 8'(oor_seen), 8'h01);
    rd(8'hFF, 8'h02);
    chk("wrap_id", got[1], 8'h90);
    rd(8'h20, 8'h04);
    for (int k = 0; k < 4; k++) chk("row80_head", got[k], EXP[32 + k]);
    rd(8'h10, 8'h00);
    repeat (4) begin
      @(negedge clk_i);
      chk("noop_rsp", 8'(l2.rsp_valid), 8'h00);
    end
    chk("served", served, 8'h60);
    // code 11b, code 00b, then a code with no row in this table
    for (int j = 0; j < 3; j++) begin
      for (int c = 0; c < 6; c++) begin
        job(3'(c), (j == 0) ? 2'h3 : ((j == 1) ? 2'h0 : 2'h1));
        m = EXP[((j == 0) ? 20 : 34) + 2 * c];
        l = EXP[((j == 0) ? 21 : 35) + 2 * c];
        chk("done", 8'(done_o), 8'h01);
        chk("error", 8'(error_o), 8'h00);
        chk("found", 8'(found_o), 8'(j < 2));
        chk("op3", op3_o, EXP[6 + 2 * c]);
        chk("op4", op4_o, EXP[7 + 2 * c]);
        chk("supported", 8'(supported_o), 8'(j < 2 && m != 8'hFF && l != 8'hFF));
        if (j < 2) begin
          chk("freq", freq_o, (j == 0) ? 8'h32 : 8'h50);
          chk("mode", mode_o, m);
          chk("lat", lat_o, l);
        end
      end
    end
    results();
  end
endmodule // tb_top
